// [pkg/dpmp_pkg.sv]
// shared constants and types for the dual port mailbox pair
package dpmp_pkg;
  localparam int unsigned MAIL_WIDTH      = 36;
  localparam logic [35:0] MAIL_RESET      = 36'h0;
  localparam logic        FULL_N_RESET    = 1'b1;
  localparam logic        CLK_PREV_RESET  = 1'b0;
  localparam logic        OE_RESET        = 1'b0;
  localparam logic        PORT_A_WRITE    = 1'b1;
  localparam logic        PORT_B_WRITE    = 1'b0;

  typedef logic [MAIL_WIDTH-1:0] dpmp_word_type;

  typedef struct packed {
    logic chip_select_n;
    logic direction;
    logic transfer_gate;
    logic mailbox_select;
  } dpmp_port_ctrl_type;

  // true when the port asks for a transfer in the given direction
  function automatic logic dpmp_selected(input dpmp_port_ctrl_type c,
                                         input logic want_dir);
    dpmp_selected = !c.chip_select_n && c.transfer_gate
                    && (c.direction == want_dir);
  endfunction : dpmp_selected
endpackage : dpmp_pkg

// [verilog/dpmp_mailbox_pair.sv]
// two mail registers with full flags between port a and port b
// Overview of operation
// - two 36-bit mail registers, one each way
// - mailbox select steers transfer to mail
// - port a write stores a-to-b word
// - port b write stores b-to-a word
// - accepted write drives full flag low
// - writes ignored while full flag low
// - port b out: fifo or a-to-b mail
// - port a out always b-to-a mail
// - port b mail read releases a-to-b flag
// - port a mail read releases b-to-a flag
// - reads leave stored mail unchanged
module dpmp_mailbox_pair
  import dpmp_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               nrst_in,
  input  wire logic               port_a_clock_in,
  input  wire logic               port_b_clock_in,
  input  wire dpmp_port_ctrl_type port_a_ctrl_in,
  input  wire dpmp_port_ctrl_type port_b_ctrl_in,
  input  wire dpmp_word_type      port_a_data_bus_in,
  input  wire dpmp_word_type      port_b_data_bus_in,
  input  wire dpmp_word_type      fifo_output_word_in,
  output logic [35:0]             port_a_data_bus_out,
  output logic                    port_a_data_bus_oe_out,
  output logic [35:0]             port_b_data_bus_out,
  output logic                    port_b_data_bus_oe_out,
  output logic                    a_to_b_mail_full_n_out,
  output logic                    b_to_a_mail_full_n_out
);

  dpmp_word_type a_to_b_mail_register;
  dpmp_word_type b_to_a_mail_register;
  dpmp_word_type next_a_to_b_mail_register;
  dpmp_word_type next_b_to_a_mail_register;
  logic          port_a_clock_prev;
  logic          port_b_clock_prev;
  logic          a_to_b_mail_full_n;
  logic          b_to_a_mail_full_n;
  logic          next_a_to_b_mail_full_n;
  logic          next_b_to_a_mail_full_n;
  logic          port_a_edge;
  logic          port_b_edge;
  logic          a_mail_write;
  logic          a_mail_read;
  logic          b_mail_write;
  logic          b_mail_read;
  logic          a_mail_accept;
  logic          b_mail_accept;
  dpmp_word_type next_port_a_data_bus;
  dpmp_word_type next_port_b_data_bus;
  logic          next_port_a_oe;
  logic          next_port_b_oe;

  // rising edge of a sampled port clock: high now, low one mclk ago
  function automatic logic port_rise(input logic now_level,
                                     input logic prev_level);
    port_rise = now_level && !prev_level;
  endfunction : port_rise

  // a mail transfer on one port in the wanted direction
  function automatic logic mail_access(input logic               rise,
                                       input dpmp_port_ctrl_type ctrl,
                                       input logic               want_dir);
    mail_access = rise && ctrl.mailbox_select
                  && dpmp_selected(ctrl, want_dir);
  endfunction : mail_access

  // set beats clear: a far read in the same cycle must not lose new mail
  function automatic logic flag_next(input logic full_n,
                                     input logic accept,
                                     input logic far_read);
    if (accept) begin
      flag_next = 1'b0;
    end else if (far_read) begin
      flag_next = 1'b1;
    end else begin
      flag_next = full_n;
    end
  endfunction : flag_next

  // drive only while selected for a read; the gate is not needed here
  function automatic logic drive_enable(input dpmp_port_ctrl_type ctrl,
                                        input logic               write_dir);
    drive_enable = !ctrl.chip_select_n && (ctrl.direction != write_dir);
  endfunction : drive_enable

  // port clocks arrive synchronous to mclk, so one history flop suffices
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_a_clock_prev <= CLK_PREV_RESET;
    end else begin
      port_a_clock_prev <= port_a_clock_in;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_b_clock_prev <= CLK_PREV_RESET;
    end else begin
      port_b_clock_prev <= port_b_clock_in;
    end
  end

  assign port_a_edge = port_rise(port_a_clock_in, port_a_clock_prev);
  assign port_b_edge = port_rise(port_b_clock_in, port_b_clock_prev);

  assign a_mail_write = mail_access(port_a_edge, port_a_ctrl_in,
                                    PORT_A_WRITE);
  assign a_mail_read  = mail_access(port_a_edge, port_a_ctrl_in,
                                    !PORT_A_WRITE);
  assign b_mail_write = mail_access(port_b_edge, port_b_ctrl_in,
                                    PORT_B_WRITE);
  assign b_mail_read  = mail_access(port_b_edge, port_b_ctrl_in,
                                    !PORT_B_WRITE);

  // a full mailbox refuses the write so the unread word survives
  assign a_mail_accept = a_mail_write && a_to_b_mail_full_n;
  assign b_mail_accept = b_mail_write && b_to_a_mail_full_n;

  // reads never feed the mail registers, so stored words stay intact
  always_comb begin
    next_a_to_b_mail_register = a_to_b_mail_register;
    if (a_mail_accept) begin
      next_a_to_b_mail_register = port_a_data_bus_in;
    end
  end

  always_comb begin
    next_b_to_a_mail_register = b_to_a_mail_register;
    if (b_mail_accept) begin
      next_b_to_a_mail_register = port_b_data_bus_in;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_to_b_mail_register <= MAIL_RESET;
    end else begin
      a_to_b_mail_register <= next_a_to_b_mail_register;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b_to_a_mail_register <= MAIL_RESET;
    end else begin
      b_to_a_mail_register <= next_b_to_a_mail_register;
    end
  end

  assign next_a_to_b_mail_full_n = flag_next(a_to_b_mail_full_n,
                                             a_mail_accept, b_mail_read);
  assign next_b_to_a_mail_full_n = flag_next(b_to_a_mail_full_n,
                                             b_mail_accept, a_mail_read);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_to_b_mail_full_n <= FULL_N_RESET;
    end else begin
      a_to_b_mail_full_n <= next_a_to_b_mail_full_n;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b_to_a_mail_full_n <= FULL_N_RESET;
    end else begin
      b_to_a_mail_full_n <= next_b_to_a_mail_full_n;
    end
  end

  // flags as outputs cost one more mclk of latency but come from a flop
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_to_b_mail_full_n_out <= FULL_N_RESET;
    end else begin
      a_to_b_mail_full_n_out <= a_to_b_mail_full_n;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b_to_a_mail_full_n_out <= FULL_N_RESET;
    end else begin
      b_to_a_mail_full_n_out <= b_to_a_mail_full_n;
    end
  end

  // port b shows the fifo word unless the mailbox is selected
  always_comb begin
    if (port_b_ctrl_in.mailbox_select) begin
      next_port_b_data_bus = a_to_b_mail_register;
    end else begin
      next_port_b_data_bus = fifo_output_word_in;
    end
  end

  assign next_port_a_data_bus = b_to_a_mail_register;
  assign next_port_a_oe = drive_enable(port_a_ctrl_in, PORT_A_WRITE);
  assign next_port_b_oe = drive_enable(port_b_ctrl_in, PORT_B_WRITE);

  // drivers follow the controls one mclk late; bus owner must allow for it
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_a_data_bus_out <= MAIL_RESET;
    end else begin
      port_a_data_bus_out <= next_port_a_data_bus;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_a_data_bus_oe_out <= OE_RESET;
    end else begin
      port_a_data_bus_oe_out <= next_port_a_oe;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_b_data_bus_out <= MAIL_RESET;
    end else begin
      port_b_data_bus_out <= next_port_b_data_bus;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_b_data_bus_oe_out <= OE_RESET;
    end else begin
      port_b_data_bus_oe_out <= next_port_b_oe;
    end
  end

endmodule : dpmp_mailbox_pair

// [verification/dpmp_mailbox_pair_sva.sv]
// concurrent checks on the mailbox pair ports
module dpmp_mailbox_pair_sva import dpmp_pkg::*; (
  input wire logic               mclk_in,
  input wire logic               nrst_in,
  input wire logic               port_a_clock_in,
  input wire logic               port_b_clock_in,
  input wire dpmp_port_ctrl_type port_a_ctrl_in,
  input wire dpmp_port_ctrl_type port_b_ctrl_in,
  input wire dpmp_word_type      port_a_data_bus_in,
  input wire dpmp_word_type      port_b_data_bus_in,
  input wire dpmp_word_type      fifo_output_word_in,
  input wire logic [35:0]        port_a_data_bus_out,
  input wire logic               port_a_data_bus_oe_out,
  input wire logic [35:0]        port_b_data_bus_out,
  input wire logic               port_b_data_bus_oe_out,
  input wire logic               a_to_b_mail_full_n_out,
  input wire logic               b_to_a_mail_full_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic pa, pb;
  // history clears to 0, as in the design, so edges line up
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) {pa, pb} <= 2'h0;
    else {pa, pb} <= {port_a_clock_in, port_b_clock_in};
  end
  // ctrl as {cs_n, dir, gate, mbx}; a writes on dir 1, b on dir 0
  wire ea = port_a_clock_in && !pa;
  wire eb = port_b_clock_in && !pb;
  wire aw = ea && port_a_ctrl_in == 4'h7;
  wire ar = ea && port_a_ctrl_in == 4'h3;
  wire bw = eb && port_b_ctrl_in == 4'h3;
  wire br = eb && port_b_ctrl_in == 4'h7;
  // a refused write may meet a far read, which then releases the flag
  a_set_a: assert property (aw && !br |-> ##2 !a_to_b_mail_full_n_out)
    else $error("a flag high");
  b_set_a: assert property (bw && !ar |-> ##2 !b_to_a_mail_full_n_out)
    else $error("b flag high");
  a_oe_a: assert property (port_a_data_bus_oe_out ==
    $past(!port_a_ctrl_in.chip_select_n && !port_a_ctrl_in.direction))
    else $error("a oe");
  b_oe_a: assert property (port_b_data_bus_oe_out ==
    $past(!port_b_ctrl_in.chip_select_n && port_b_ctrl_in.direction))
    else $error("b oe");
  a_clr_a: assert property (br && !aw |-> ##2 a_to_b_mail_full_n_out)
    else $error("a flag low");
  b_clr_a: assert property (ar && !bw |-> ##2 b_to_a_mail_full_n_out)
    else $error("b flag low");
  a_out_a: assert property ($fell(b_to_a_mail_full_n_out) |->
    port_a_data_bus_out == $past(port_b_data_bus_in, 2)) else $error("a out");
  b_mail_a: assert property ($fell(a_to_b_mail_full_n_out) &&
    $past(port_b_ctrl_in.mailbox_select) |->
    port_b_data_bus_out == $past(port_a_data_bus_in, 2)) else $error("b mail");
  b_fifo_a: assert property (!$past(port_b_ctrl_in.mailbox_select) |->
    port_b_data_bus_out == $past(fifo_output_word_in)) else $error("b fifo");
  mail_hold_a: assert property (!b_to_a_mail_full_n_out |=>
    $stable(port_a_data_bus_out)) else $error("mail moved");
  cover property (aw);
  cover property (bw);
  cover property (eb && port_b_ctrl_in == 4'h6);
endmodule : dpmp_mailbox_pair_sva
bind dpmp_mailbox_pair dpmp_mailbox_pair_sva u_sva (.mclk_in, .nrst_in,
  .port_a_clock_in, .port_b_clock_in, .port_a_ctrl_in, .port_b_ctrl_in,
  .port_a_data_bus_in, .port_b_data_bus_in, .fifo_output_word_in,
  .port_a_data_bus_out, .port_a_data_bus_oe_out, .port_b_data_bus_out,
  .port_b_data_bus_oe_out, .a_to_b_mail_full_n_out,
  .b_to_a_mail_full_n_out);

// [verification/dpmp_fifo_model.sv]
// fifo output register standing behind port b
module dpmp_fifo_model import dpmp_pkg::*; (
  input  wire logic               mclk_in,
  input  wire logic               nrst_in,
  input  wire logic               clk_in,
  input  wire dpmp_port_ctrl_type ctrl_in,
  output dpmp_word_type           word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // level decode: port clock pulses are one mclk wide here
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) word_out <= 36'h0;
    else if (clk_in && ctrl_in == 4'h6) word_out <= ~word_out ^ 36'h1;
  end
endmodule : dpmp_fifo_model

// [verification/test_dpmp_mailbox_pair.sv]
// self-checking bench for the mailbox pair
module test_dpmp_mailbox_pair import dpmp_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk_in = 1'b0, nrst_in = 1'b0, af, bf;
  logic               ck [2];
  dpmp_port_ctrl_type c [2];
  dpmp_word_type      d [2], fw;
  logic [35:0]        ao, bo;
  logic               ao_oe, bo_oe;
  int                 num_errors = 0, checks_done = 0;
  initial forever #50 mclk_in = ~mclk_in;
  dpmp_mailbox_pair u_dut (.mclk_in, .nrst_in, .port_a_clock_in(ck[0]),
    .port_b_clock_in(ck[1]), .port_a_ctrl_in(c[0]), .port_b_ctrl_in(c[1]),
    .port_a_data_bus_in(d[0]), .port_b_data_bus_in(d[1]),
    .fifo_output_word_in(fw), .port_a_data_bus_out(ao),
    .port_a_data_bus_oe_out(ao_oe), .port_b_data_bus_out(bo),
    .port_b_data_bus_oe_out(bo_oe), .a_to_b_mail_full_n_out(af),
    .b_to_a_mail_full_n_out(bf));
  dpmp_fifo_model u_fifo (.mclk_in, .nrst_in, .clk_in(ck[1]),
    .ctrl_in(c[1]), .word_out(fw));
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // one port clock pulse; afterwards deselect but keep mailbox select
  task op(input int p, input logic [3:0] cv, input dpmp_word_type w);
    logic oe_exp;
    oe_exp = !cv[3] && (cv[2] != (p == 0 ? PORT_A_WRITE : PORT_B_WRITE));
    @(negedge mclk_in);
    c[p] = cv;
    d[p] = w;
    ck[p] = 1'b1;
    @(negedge mclk_in);
    chk(p == 0 ? ao_oe : bo_oe, oe_exp);
    ck[p] = 1'b0;
    c[p] = {1'b1, cv[2], 1'b0, cv[0]};
    repeat (2) @(negedge mclk_in);
    chk({ao_oe, bo_oe}, 2'h0);
  endtask : op
  initial begin
    #100000 num_errors++;
    report_and_stop;
  end
  initial begin
    ck = '{1'b0, 1'b0};
    c = '{4'h8, 4'h9};
    d = '{36'h0, 36'h0};
    repeat (4) @(negedge mclk_in);
    nrst_in = 1'b1;
    chk({af, bf}, 2'h3);
    op(0, 4'h6, 36'h1_2345_6789);
    chk(af, 1'h1);
    op(0, 4'h7, 36'h9_abcd_ef01);
    chk(af, 1'h0);
    op(0, 4'h7, 36'h0_5555_aaaa);
    chk(bo, 36'h9_abcd_ef01);
    op(1, 4'h7, 36'h0);
    chk(af, 1'h1);
    chk(bo, 36'h9_abcd_ef01);
    op(1, 4'h3, 36'hc_0ffe_e123);
    chk(bf, 1'h0);
    chk(ao, 36'hc_0ffe_e123);
    op(0, 4'h3, 36'h0);
    chk(bf, 1'h1);
    chk(ao, 36'hc_0ffe_e123);
    op(1, 4'h6, 36'h0);
    chk(bo, 36'hf_ffff_fffe);
    report_and_stop;
  end
endmodule : test_dpmp_mailbox_pair
